// ===== core/clock_switch_seq.sv
// break-before-make sequencer for the reference and pll clock selects
`timescale 1ns/1ns
module clock_switch_seq
  import pll_clk_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // request and selects
  input  wire logic want_pll,
  output      logic sel_ref,
  output      logic sel_pll
);

  sw_state_t        state;
  logic [GAP_W-1:0] gap;

  // state walk with a dead gap where neither select is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SW_REF;
      gap   <= '0;
    end else begin
      unique case (state)
        SW_REF: begin
          gap <= '0;
          if (want_pll) state <= SW_TO_PLL;
        end
        SW_PLL: begin
          gap <= '0;
          if (!want_pll) state <= SW_TO_REF;
        end
        SW_TO_PLL, SW_TO_REF: begin
          gap <= gap + GAP_W'(1);
          if (gap == GAP_W'(SWITCH_GAP_CYCLES - 1)) state <= want_pll ? SW_PLL : SW_REF;
        end
      endcase
    end
  end

  // selects registered from the state and the request, never both high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_ref <= 1'h1;
      sel_pll <= 1'h0;
    end else begin
      sel_ref <= (state == SW_REF) && !want_pll;
      sel_pll <= (state == SW_PLL) && want_pll;
    end
  end

endmodule

// ===== core/level_sync.sv
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ===== core/pll_clk_pkg.sv
// package: register map, field layout, types and helpers for clock and power-down control
package pll_clk_pkg;

  // bus and register map
  localparam logic [31:0] ADDR_FIRST_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_CLK_SETUP  = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS     = 32'h0000_0008;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic        HRESP_OKAY      = 1'h0;

  // reset values: differential input, pll powered down and in reset
  localparam logic [15:0] CLK_SETUP_RESET  = 16'h0020;
  localparam logic [15:0] CLK_SETUP_WMASK  = 16'hFFFE;
  localparam logic [7:0]  FIRST_CTRL_RESET = 8'h00;
  localparam logic [7:0]  FIRST_CTRL_WMASK = 8'hF0;

  // clock setup register fields
  localparam int CS_LOCK     = 0;
  localparam int CS_RESET_N  = 1;
  localparam int CS_VCO_ALT  = 2;
  localparam int CS_REF_DIV2 = 3;
  localparam int CS_LOW_RNG  = 4;
  localparam int CS_PLL_PD   = 5;
  localparam int CS_MODE_HI  = 7;
  localparam int CS_N_LO     = 9;
  localparam int CS_N_HI     = 13;
  localparam int CS_FB_DIV2  = 14;
  localparam int CS_OUT_DIV2 = 15;

  // first control register fields
  localparam int FC_CLKIN_PD = 4;
  localparam int FC_DAC_PD   = 5;
  localparam int FC_DIG_PD   = 6;
  localparam int FC_FULL_PD  = 7;

  // status register fields
  localparam int ST_LOCK      = 0;
  localparam int ST_SEL_PLL   = 1;
  localparam int ST_SEL_REF   = 2;
  localparam int ST_LOCK_LOST = 3;
  localparam int ST_PD_PIN    = 4;
  localparam int ST_FACTOR_LO = 8;
  localparam int FACTOR_W     = 9;

  // feedback code zero stands for divide by 32
  localparam logic [5:0] N_ZERO_AS = 6'h20;

  // dead time between dropping one clock select and raising the other
  localparam int HCLK_PERIOD_NS    = 50;
  localparam int SWITCH_GAP_NS     = 100;
  localparam int SWITCH_GAP_CYCLES =
    (SWITCH_GAP_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;
  localparam int GAP_W             = 4;

  typedef enum logic [2:0] {
    CLKIN_DIFF = 3'h1,
    CLKIN_XTAL = 3'h2,
    CLKIN_CMOS = 3'h4
  } clkin_mode_t;

  typedef enum logic [3:0] {
    SW_REF    = 4'h1,
    SW_TO_PLL = 4'h2,
    SW_PLL    = 4'h4,
    SW_TO_REF = 4'h8
  } sw_state_t;

  typedef struct packed {
    logic       powerdown;
    logic       reset_n;
    logic       low_range;
    logic       ref_div2;
    logic       vco_alt;
    logic [4:0] fb_n;
    logic       fb_div2;
    logic       out_div2;
  } pll_ctrl_t;

  typedef struct packed {
    logic digital;
    logic dac;
    logic dac_logic;
    logic clock_input;
    logic pll;
  } pd_ctrl_t;

  // multiplication factor in quarters: n, x2 feedback, /2 ref, /2 out
  function automatic logic [FACTOR_W-1:0] mult_quarters(input logic [4:0] code,
                                                       input logic       fb2,
                                                       input logic       ref2,
                                                       input logic       out2);
    logic [FACTOR_W-1:0] q;
    q = {1'h0, ((code == 5'h00) ? N_ZERO_AS : {1'h0, code}), 2'h0};
    q = fb2 ? (q << 1) : q;
    q = ref2 ? (q >> 1) : q;
    q = out2 ? (q >> 1) : q;
    return q;
  endfunction

  // clock input mode from the three-bit field
  function automatic clkin_mode_t decode_clkin(input logic [2:0] field);
    clkin_mode_t m;
    if (field[1]) begin
      m = CLKIN_XTAL;
    end else if (field[2]) begin
      m = CLKIN_CMOS;
    end else begin
      m = CLKIN_DIFF;
    end
    return m;
  endfunction

endpackage

// ===== core/pll_clock_and_powerdown_ctrl.sv
// pll configuration, lock tracking, clock select and power-down control behind ahb-lite
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module pll_clock_and_powerdown_ctrl
  import pll_clk_pkg::*;
(
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output      logic                hreadyout,
  output      logic [31:0]         hrdata,
  output      logic                hresp,
  // pins from outside the clock domain
  input  wire logic                pll_lock,
  input  wire logic                powerdown_scheme_pin,
  // pll and analog controls
  output      pll_ctrl_t           pll_ctrl,
  output      clkin_mode_t         clkin_mode,
  output      pd_ctrl_t            pd_ctrl,
  output      logic [FACTOR_W-1:0] mult_factor,
  // system clock selects
  output      logic                sel_ref_clock,
  output      logic                sel_pll_clock
);

  // register contents
  logic [15:0] clock_setup_register;
  logic [7:0]  first_control_register;
  logic        lock_lost;

  // next values, also used to forward write data to a following read
  logic [15:0] next_clock_setup;
  logic [7:0]  next_first_control;
  logic        next_lock_lost;

  // bus data-phase state
  logic        wr_pending;
  logic [31:0] wr_addr;

  // synchronised pins and lock history
  logic        lock_sync;
  logic        scheme_sync;
  logic        lock_prev;

  // decoded request and write strobes
  logic        addr_phase;
  logic        wr_now;
  logic        wr_first_ctrl;
  logic        wr_clk_setup;
  logic        wr_status;

  // pll use and clock request
  logic        pll_wanted;
  logic        want_pll;
  logic        lock_fall;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------

  level_sync #(
    .WIDTH (1)
  ) u_lock_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (pll_lock),
    .sync_out (lock_sync)
  );

  // scheme pin synchronised before use
  level_sync #(
    .WIDTH (1)
  ) u_scheme_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (powerdown_scheme_pin),
    .sync_out (scheme_sync)
  );

  // ---------------------------------------------------------------
  // ahb-lite address and data phase
  // ---------------------------------------------------------------

  // a transfer is taken when selected, active and the bus is ready
  assign addr_phase = hsel && htrans[1] && hready;

  // write data phase completes on the edge after the address phase
  assign wr_now        = wr_pending && hready;
  assign wr_first_ctrl = wr_now && (wr_addr == ADDR_FIRST_CTRL);
  assign wr_clk_setup  = wr_now && (wr_addr == ADDR_CLK_SETUP);
  assign wr_status     = wr_now && (wr_addr == ADDR_STATUS);

  // capture write address phase for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'h0;
      wr_addr    <= '0;
    end else if (hready) begin
      wr_pending <= addr_phase && hwrite;
      if (addr_phase && hwrite) begin
        wr_addr <= haddr;
      end
    end
  end

  // zero wait states and always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'h1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'h1;
      hresp     <= HRESP_OKAY;
    end
  end

  // ---------------------------------------------------------------
  // register next values
  // ---------------------------------------------------------------

  // clock setup: lock bit is never stored, only read back
  always_comb begin
    next_clock_setup = clock_setup_register;
    if (wr_clk_setup) begin
      next_clock_setup = (hwdata[15:0] & CLK_SETUP_WMASK)
                       | (clock_setup_register & ~CLK_SETUP_WMASK);
    end
  end

  // first control: only the power-down field is kept
  always_comb begin
    next_first_control = first_control_register;
    if (wr_first_ctrl) begin
      next_first_control = hwdata[7:0] & FIRST_CTRL_WMASK;
    end
  end

  // lock lost flag: a falling lock in the clear cycle survives
  always_comb begin
    next_lock_lost = lock_lost;
    if (wr_status && hwdata[ST_LOCK_LOST]) begin
      next_lock_lost = 1'h0;
    end
    if (lock_fall) begin
      next_lock_lost = 1'h1;
    end
  end

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_setup_register <= CLK_SETUP_RESET;
    end else begin
      clock_setup_register <= next_clock_setup;
    end
  end

  // power-down control bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_control_register <= FIRST_CTRL_RESET;
    end else begin
      first_control_register <= next_first_control;
    end
  end

  // sticky lock lost event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_lost <= 1'h0;
      lock_prev <= 1'h0;
    end else begin
      lock_lost <= next_lock_lost;
      lock_prev <= lock_sync;
    end
  end

  // ---------------------------------------------------------------
  // read data, taken at the address phase from forwarded values
  // ---------------------------------------------------------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_phase && !hwrite) begin
      unique case (haddr)
        ADDR_FIRST_CTRL: hrdata <= {24'h000000, next_first_control};
        ADDR_CLK_SETUP: begin
          hrdata <= {16'h0000, next_clock_setup[15:1], lock_sync};
        end
        ADDR_STATUS: begin
          hrdata                                   <= '0;
          hrdata[ST_LOCK]                          <= lock_sync;
          hrdata[ST_SEL_PLL]                       <= sel_pll_clock;
          hrdata[ST_SEL_REF]                       <= sel_ref_clock;
          hrdata[ST_LOCK_LOST]                     <= next_lock_lost;
          hrdata[ST_PD_PIN]                        <= scheme_sync;
          hrdata[ST_FACTOR_LO +: FACTOR_W]         <= mult_factor;
        end
        default: hrdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pll control outputs
  // ---------------------------------------------------------------

  assign pll_wanted = !clock_setup_register[CS_PLL_PD];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_ctrl <= '{powerdown: 1'h1, reset_n: 1'h0, default: '0};
    end else begin
      // pll powered down, also in full power-down under the pin scheme
      pll_ctrl.powerdown <= clock_setup_register[CS_PLL_PD]
                         || (scheme_sync && first_control_register[FC_FULL_PD]);
      pll_ctrl.reset_n   <= clock_setup_register[CS_RESET_N];
      pll_ctrl.low_range <= clock_setup_register[CS_LOW_RNG];
      pll_ctrl.ref_div2  <= clock_setup_register[CS_REF_DIV2];
      pll_ctrl.vco_alt   <= clock_setup_register[CS_VCO_ALT];
      pll_ctrl.fb_n      <= clock_setup_register[CS_N_HI:CS_N_LO];
      pll_ctrl.fb_div2   <= clock_setup_register[CS_FB_DIV2];
      pll_ctrl.out_div2  <= clock_setup_register[CS_OUT_DIV2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mult_factor <= '0;
    end else begin
      mult_factor <= mult_quarters(clock_setup_register[CS_N_HI:CS_N_LO],
                                   clock_setup_register[CS_FB_DIV2],
                                   clock_setup_register[CS_REF_DIV2],
                                   clock_setup_register[CS_OUT_DIV2]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clkin_mode <= CLKIN_DIFF;
    end else begin
      clkin_mode <= decode_clkin(clock_setup_register[CS_MODE_HI:CS_PLL_PD]);
    end
  end

  // ---------------------------------------------------------------
  // lock tracking and system clock select
  // ---------------------------------------------------------------

  // pll used only while running and locked
  assign want_pll  = pll_wanted && clock_setup_register[CS_RESET_N] && lock_sync;

  // loss of lock while the setup power-down bit is clear, even in reset or in pin-scheme full power-down
  assign lock_fall = lock_prev && !lock_sync && pll_wanted;

  clock_switch_seq u_switch (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .want_pll (want_pll),
    .sel_ref  (sel_ref_clock),
    .sel_pll  (sel_pll_clock)
  );

  // ---------------------------------------------------------------
  // power-down scheme
  // ---------------------------------------------------------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_ctrl <= '0;
    end else if (!scheme_sync) begin
      pd_ctrl.digital     <= first_control_register[FC_DIG_PD];
      pd_ctrl.dac         <= first_control_register[FC_DAC_PD];
      pd_ctrl.dac_logic   <= first_control_register[FC_DAC_PD];
      pd_ctrl.clock_input <= first_control_register[FC_CLKIN_PD];
      pd_ctrl.pll         <= clock_setup_register[CS_PLL_PD];
    end else begin
      pd_ctrl.digital     <= 1'h1;
      pd_ctrl.dac_logic   <= 1'h1;
      pd_ctrl.dac         <= first_control_register[FC_FULL_PD];
      pd_ctrl.clock_input <= first_control_register[FC_FULL_PD];
      pd_ctrl.pll         <= first_control_register[FC_FULL_PD]
                          || clock_setup_register[CS_PLL_PD];
    end
  end

  // hsize is accepted for any width; every register is a whole word
  logic unused_hsize;
  assign unused_hsize = ^hsize;

endmodule

// ===== sim/ahb_host_model.sv
// bus master standing in for the host that programs the controller
`timescale 1ns/1ns
module ahb_host_model
  import pll_clk_pkg::*;
(
  // clock
  input  wire logic        hclk,
  // bus towards the slave
  output      logic        hsel,
  output      logic [31:0] haddr,
  output      logic [1:0]  htrans,
  output      logic        hwrite,
  output      logic [2:0]  hsize,
  output      logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // idle bus at time zero, whole-word size only
  initial begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    // address lines are scrambled once the address phase is over
    hsel <= 1'h0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= wr ? wd : ~wd;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask
endmodule

// ===== sim/pll_ctrl_assertions.sv
// concurrent checks on the clock and power-down controller ports
`timescale 1ns/1ns
module pll_ctrl_checker
  import pll_clk_pkg::*;
(
  // clock and reset
  input wire logic                hclk,
  input wire logic                hresetn,
  // bus
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  // pins and controls
  input wire logic                pll_lock,
  input wire logic                powerdown_scheme_pin,
  input wire pll_ctrl_t           pll_ctrl,
  input wire pd_ctrl_t            pd_ctrl,
  input wire logic [FACTOR_W-1:0] mult_factor,
  input wire logic                sel_ref_clock,
  input wire logic                sel_pll_clock
);
  logic [FACTOR_W-1:0] quarters;
  logic                pll_on;
  // expected factor in quarters from the live divider fields
  always_comb begin
    quarters = {1'h0, (pll_ctrl.fb_n == 5'h00) ? 6'h20 : {1'h0, pll_ctrl.fb_n}, 2'h0};
    if (pll_ctrl.fb_div2) quarters = quarters << 1;
    if (pll_ctrl.ref_div2) quarters = quarters >> 1;
    if (pll_ctrl.out_div2) quarters = quarters >> 1;
  end
  // loop powered and out of reset
  assign pll_on = pll_ctrl.reset_n && !pll_ctrl.powerdown;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_locked_run;
    (pll_lock && pll_on)[*8] ##1 (pll_lock && pll_on)[*6];
  endsequence
  sequence s_unlocked_run;
    (!pll_lock)[*8] ##1 (!pll_lock)[*6];
  endsequence
  sequence s_status_read;
    hsel && htrans[1] && hready && !hwrite && haddr == ADDR_STATUS;
  endsequence
  chk_sel_exclusive: assert property (!(sel_ref_clock && sel_pll_clock))
    else $error("both clock selects high");
  chk_ref_to_pll: assert property ($fell(sel_ref_clock) |-> !sel_pll_clock[*2])
    else $error("pll select rose without gap");
  chk_pll_to_ref: assert property ($fell(sel_pll_clock) |-> !sel_ref_clock[*2])
    else $error("reference select rose without gap");
  chk_lock_pll: assert property (s_locked_run |-> sel_pll_clock)
    else $error("locked loop not selected");
  chk_unlock_ref: assert property (s_unlocked_run |-> sel_ref_clock)
    else $error("unlocked loop still selected");
  chk_off_ref: assert property ((!pll_on)[*8] |-> !sel_pll_clock)
    else $error("pll selected while off");
  chk_factor_value: assert property ($past(hresetn) |-> mult_factor == quarters)
    else $error("factor does not match dividers");
  chk_status_sel: assert property (s_status_read |=>
    hrdata[2:1] == $past({sel_ref_clock, sel_pll_clock}) && hrdata[16:8] == $past(mult_factor))
    else $error("status read disagrees with outputs");
  chk_pin_mode: assert property (powerdown_scheme_pin[*5] |-> pd_ctrl.digital &&
    pd_ctrl.dac_logic && pd_ctrl.dac == pd_ctrl.clock_input && (pd_ctrl.pll || !pd_ctrl.dac))
    else $error("pin power-down mode wrong");
  chk_soft_mode: assert property ((!powerdown_scheme_pin)[*5] |->
    pd_ctrl.pll == pll_ctrl.powerdown && pd_ctrl.dac == pd_ctrl.dac_logic)
    else $error("software power-down mode wrong");
endmodule

bind pll_clock_and_powerdown_ctrl pll_ctrl_checker chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .pll_lock(pll_lock),
  .powerdown_scheme_pin(powerdown_scheme_pin), .pll_ctrl(pll_ctrl), .pd_ctrl(pd_ctrl),
  .mult_factor(mult_factor), .sel_ref_clock(sel_ref_clock), .sel_pll_clock(sel_pll_clock)
);

// ===== sim/testbench.sv
// self-checking bench for the clock and power-down controller
`timescale 1ns/1ns
module testbench
  import pll_clk_pkg::*;
;
  localparam int LOCK_DELAY = 20;
  localparam int RECOVER    = 10;
  localparam int CEILING    = 20000;
  logic                hclk = 1'h0;
  logic                hresetn = 1'h0;
  logic                hsel, hwrite, hreadyout, hresp;
  logic [31:0]         haddr, hwdata, hrdata, rd, d;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic                pll_lock = 1'h0;
  logic                powerdown_scheme_pin = 1'h0;
  logic                unlock_req = 1'h0;
  pll_ctrl_t           pll_ctrl;
  clkin_mode_t         clkin_mode;
  pd_ctrl_t            pd_ctrl;
  logic [FACTOR_W-1:0] mult_factor;
  logic                sel_ref_clock, sel_pll_clock;
  logic [31:0]         rng = 32'h0000_DF16;
  int                  lock_cnt = 0;
  int                  cycles = 0;
  int                  bad_count = 0;
  int                  samples_checked = 0;
  logic [15:0]         setup_m = 16'h0020;
  logic [7:0]          first_m = 8'h00;
  logic                lost_m = 1'h0;

  always #25 hclk = ~hclk;

  ahb_host_model host_u (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  pll_clock_and_powerdown_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .pll_lock(pll_lock), .powerdown_scheme_pin(powerdown_scheme_pin), .pll_ctrl(pll_ctrl),
    .clkin_mode(clkin_mode), .pd_ctrl(pd_ctrl), .mult_factor(mult_factor),
    .sel_ref_clock(sel_ref_clock), .sel_pll_clock(sel_pll_clock));

  // loop stand-in: lock a while after it is powered and out of reset
  always @(posedge hclk) begin
    if (pll_ctrl.powerdown || !pll_ctrl.reset_n || unlock_req) begin
      lock_cnt <= 0;
      pll_lock <= 1'h0;
    end else begin
      lock_cnt <= lock_cnt + 1;
      if (lock_cnt == LOCK_DELAY) pll_lock <= 1'h1;
    end
  end

  // hang guard
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      bad_count = bad_count + 1;
      close_out();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // factor in quarters: n (zero counts as 32), x2, /2 reference, /2 output
  function automatic int exp_factor(input logic [15:0] s);
    int n;
    n = s[13:9];
    if (n == 0) n = 32;
    n = n * 4;
    if (s[14]) n = n * 2;
    if (s[3]) n = n / 2;
    if (s[15]) n = n / 2;
    return n;
  endfunction

  // clock input mode table
  function automatic logic [2:0] exp_clkin(input logic [2:0] f);
    case (f)
      3'h2, 3'h3, 3'h6, 3'h7: return CLKIN_XTAL;
      3'h4, 3'h5: return CLKIN_CMOS;
      default: return CLKIN_DIFF;
    endcase
  endfunction

  // power-down lines: digital, dac, dac logic, clock input, pll
  function automatic logic [4:0] exp_pd(input logic [7:0] f, input logic p, input logic s5);
    return p ? {1'h1, f[7], 1'h1, f[7], f[7] | s5} : {f[6], f[5], f[5], f[4], s5};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("counts: %0d checked, %0d mismatched", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic write(input logic [31:0] a, input logic [31:0] v);
    host_u.xfer(1'h1, a, v, rd);
  endtask

  // compare every output and register view with the model once settled
  task automatic verify();
    logic [15:0] s;
    logic        w;
    repeat (8) @(posedge hclk);
    s = setup_m;
    w = !s[5] && s[1] && pll_lock;
    check(32'(pll_ctrl), {20'h0, s[5] | (powerdown_scheme_pin & first_m[7]), s[1], s[4], s[3],
      s[2], s[13:9], s[14], s[15]});
    check({30'h0, hreadyout, hresp}, {30'h0, 1'h1, HRESP_OKAY});
    check(32'(mult_factor), exp_factor(s));
    check(32'(clkin_mode), {29'h0, exp_clkin(s[7:5])});
    check(32'(pd_ctrl), {27'h0, exp_pd(first_m, powerdown_scheme_pin, s[5])});
    check({30'h0, sel_pll_clock, sel_ref_clock}, {30'h0, w, !w});
    host_u.xfer(1'h0, ADDR_CLK_SETUP, rng, rd);
    check(rd, {16'h0, s[15:1], pll_lock});
    host_u.xfer(1'h0, ADDR_FIRST_CTRL, rng, rd);
    check(rd, {24'h0, first_m[7:4], 4'h0});
    host_u.xfer(1'h0, ADDR_STATUS, rng, rd);
    check(rd, {15'h0, 9'(exp_factor(s)), 3'h0, powerdown_scheme_pin, lost_m, !w, w, pll_lock});
    host_u.xfer(1'h0, 32'h0000_000C, rng, rd);
    check(rd, 32'h0);
  endtask

  task automatic wait_sel(input logic v);
    int k;
    k = 0;
    while (sel_pll_clock !== v && k < 200) begin
      @(posedge hclk);
      k++;
    end
    check({31'h0, sel_pll_clock}, {31'h0, v});
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    verify();
    $display("test reset values done");
    write(32'h0000_000C, rng);
    // divider and input mode sweep, loop logic held in reset
    for (int i = 0; i < 16; i++) begin
      rng = xs(rng);
      d = {16'h0, rng[15:8], i[2:0], rng[4:2], 1'h0, rng[0]};
      if (i == 0) d[15:9] = 7'h20;
      if (i == 1) d[13:9] = 5'h1F;
      write(ADDR_CLK_SETUP, d);
      setup_m = {d[15:1], 1'h0};
      verify();
    end
    $display("test divider sweep done");
    // start loop at 8x with lock released
    write(ADDR_CLK_SETUP, 32'h0000_1002);
    setup_m = 16'h1002;
    wait_sel(1'h1);
    verify();
    unlock_req <= 1'h1;
    wait_sel(1'h0);
    lost_m = 1'h1;
    verify();
    write(ADDR_STATUS, 32'hFFFF_FFFF);
    lost_m = 1'h0;
    verify();
    unlock_req <= 1'h0;
    wait_sel(1'h1);
    verify();
    write(ADDR_CLK_SETUP, 32'h0000_1000);
    setup_m = 16'h1000;
    lost_m = 1'h1;
    verify();
    write(ADDR_CLK_SETUP, 32'h0000_1020);
    setup_m = 16'h1020;
    verify();
    write(ADDR_STATUS, 32'h0000_0008);
    lost_m = 1'h0;
    $display("test lock and switch done");
    // both schemes across all four control bits
    for (int j = 0; j < 32; j++) begin
      rng = xs(rng);
      powerdown_scheme_pin <= j[4];
      write(ADDR_FIRST_CTRL, {24'h0, j[3:0], rng[3:0]});
      first_m = {j[3:0], rng[3:0]};
      repeat (RECOVER) @(posedge hclk);
      verify();
    end
    $display("test power-down done");
    close_out();
  end
endmodule
